// >>> logic/adc_result_word_serializer.sv
// result word assembly, serial output port and conversion clock select
//
// Behaviour
// - 24-bit word, four status then result
// - bit 23 busy high while converting
// - busy on data out when select low
// - bit 22 channel, single-input variant low
// - bit 21 sign, high for positive
// - bit 20 set outside zero to reference
// - bits 19..0 result, MSB first
// - select high: output off, clocks ignored
// - busy falls at once on completion
// - bit 22 presented on first falling edge
// - bit 0 on 23rd falling edge
// - 24th falling edge starts conversion, output high
// - range codes wrap as documented
// - saturate beyond the extended range
// - select low 60Hz, high 50Hz
// - select change harms only current conversion
// - detect external clock, stop internal oscillator
// - external notch is clock over 2560
// - no external clock: back to internal
// - output starts on rising clock, select low
// - output ends after 24 bits or select rise
// - eight extra clocks give high bits
`timescale 1ns/1ps
module adc_result_word_serializer
  import adcws_pkg::*;
#(
  parameter bit          TWO_INPUTS = 1'b1,
  parameter int unsigned DET_CYCLES = DET_WINDOW
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              csN,          // chip select pin
  input  wire logic              sck,          // serial clock pin
  input  wire logic              rejection_select_pin,
  output logic                   sdoOut,       // serial data out
  output logic                   sdoOe,        // high while driving
  // filter side: conversion handshake
  output logic                   convStart,    // one-cycle start pulse
  input  wire logic              convDone,     // one-cycle completion
  input  wire adcws_result_type  convResult,   // valid with convDone
  input  wire logic              convChan,     // channel in use
  input  wire logic              convTick,     // internal oscillator tick
  output logic                   convBusy,     // conversion running
  output logic                   notch50,      // 1: 50Hz, 0: 60Hz
  output logic                   extClkSel,    // external clock in use
  output logic                   intOscEn,     // internal oscillator on
  output logic                   convClkEn,    // selected conversion tick
  output logic                   resultLost    // fifo full on completion
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] csSync;   // chip select pair
  logic [1:0] sckSync;  // serial clock pair
  logic [1:0] rsSync;   // rejection select pair
  logic       sckPrev;  // last synced clock, for edges
  logic       rsPrev;   // last synced select, for edges

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      csSync  <= 2'h3;
      sckSync <= 2'h0;
      rsSync  <= 2'h0;
      sckPrev <= 1'b0;
      rsPrev  <= 1'b0;
    end else begin
      csSync  <= {csSync[0], csN};
      sckSync <= {sckSync[0], sck};
      rsSync  <= {rsSync[0], rejection_select_pin};
      sckPrev <= sckSync[1];
      rsPrev  <= rsSync[1];
    end
  end

  // the host's pins move at any time; two flops tame them before use,
  // so every edge seen here trails the pin by about two cycles
  wire csLow   = !csSync[1];
  wire sckRise = sckSync[1] && !sckPrev;
  wire sckFall = !sckSync[1] && sckPrev;
  wire rsEdge  = rsSync[1] != rsPrev;

  ////////////////////////////////////////////////////////////////////////
  // word assembly with saturation
  function automatic logic [23:0] build_word(input adcws_result_type r,
                                             input logic chan);
    logic [19:0] v;
    v = r.value;
    // clamp beyond the extended span; the filter may overshoot
    if (!r.sign && r.range && v < SAT_LOW) begin
      v = SAT_LOW;
    end else if (r.sign && r.range && v > SAT_HIGH) begin
      v = SAT_HIGH;
    end
    // busy low in a finished word; range wrap coding kept as given
    build_word = {1'b0, chan, r.sign, r.range, v};
  endfunction : build_word

  // the single-input variant ties the channel bit low
  wire             chanBit  = TWO_INPUTS ? convChan : 1'b0;
  wire [23:0]      doneWord = build_word(convResult, chanBit);
  logic            fifoInReady;
  logic [23:0]     fifoOutData;
  logic            fifoOutValid;
  logic            fifoPop;

  // finished words queue here until the serializer claims one
  adcws_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) uFifo (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .inData   (doneWord),
    .inValid  (convDone),
    .inReady  (fifoInReady),
    .outData  (fifoOutData),
    .outValid (fifoOutValid),
    .outReady (fifoPop)
  );

  ////////////////////////////////////////////////////////////////////////
  // conversion cycle state machine
  // convert, sleep and data output follow one another in a ring; a cut
  // read and a full read both lead back to convert
  adcws_state_type state;
  adcws_state_type next_state;
  logic [23:0]     shiftReg;   // output shift register
  logic [5:0]      bitCount;   // falling edges seen in output and convert states
  logic            doStart;    // begin a new conversion

  // sleep leaves only on rising clock with select low
  wire enterOutput = (state == ST_SLEEP) && csLow && sckRise;
  // ends after 24 falls, or when select rises mid output
  wire endByCount  = (state == ST_OUTPUT) && csLow && sckFall &&
                     (bitCount == 6'(WORD_BITS - 1));
  wire endBySelect = (state == ST_OUTPUT) && !csLow;
  // an empty fifo holds the device in convert until a finished word arrives
  wire convFinish  = (state == ST_CONVERT) && fifoOutValid;

  // the word is claimed as convert ends; sleep then holds it static
  assign fifoPop = convFinish;

  always_comb begin
    next_state = state;
    doStart    = 1'b0;
    case (state)
      ST_CONVERT: begin
        if (convFinish) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (enterOutput) begin
          next_state = ST_OUTPUT;
        end
      end
      ST_OUTPUT: begin
        if (endByCount || endBySelect) begin
          next_state = ST_CONVERT;
          doStart    = 1'b1;
        end
      end
      default: begin
        next_state = ST_CONVERT;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= ST_CONVERT;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shift register: falls shift in ones; trailing bits read high from the busy level
  // falls with select high never reach it, so a parked word survives
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      shiftReg <= WORD_RST;
      bitCount <= 6'h00;
    end else if (convFinish) begin
      shiftReg <= fifoOutData;
      bitCount <= 6'h00;
    end else if (csLow && sckFall &&
                 (state == ST_OUTPUT || state == ST_CONVERT)) begin
      // only falls with select low move the register
      shiftReg <= {shiftReg[22:0], 1'b1};
      bitCount <= (bitCount == 6'h3F) ? bitCount : bitCount + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial data pin: busy level outside output, word bit during it
  // convert shows busy only, so a word cut short by select cannot
  // leak its leftover bits while the host polls the pin
  wire busyLevel = (state == ST_CONVERT);
  wire shiftOut  = (state == ST_OUTPUT);
  wire next_sdo  = shiftOut ? shiftReg[BUSY_POS] : busyLevel;

  // data level register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sdoOut <= 1'h1;
    end else begin
      sdoOut <= next_sdo;
    end
  end

  // driver enable follows the synced select
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sdoOe <= 1'h0;
    end else begin
      sdoOe <= csLow;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // external clock detection over a window of mclk cycles
  // a steady level gives no edges, so a tied pin reads as internal;
  // the window holds two edges of the slowest clock allowed while
  // staying short enough to notice a lost clock quickly
  logic [$clog2(DET_WINDOW+1)-1:0] winCount;  // window timer
  logic [1:0]                      edgeCount; // edges this window
  logic                            extSeen;   // detection result
  wire winEnd = (winCount == '0);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      winCount  <= '0;
      edgeCount <= 2'h0;
      extSeen   <= 1'b0;
    end else if (winEnd) begin
      // count edges, decide once per window
      winCount  <= ($clog2(DET_WINDOW+1))'(DET_CYCLES - 1);
      extSeen   <= (edgeCount >= 2'(DET_EDGES));
      edgeCount <= 2'h0;
    end else begin
      winCount  <= winCount - 1'b1;
      if (rsEdge && edgeCount != 2'h3) begin
        edgeCount <= edgeCount + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // source select, switched only between conversions for no glitch
  // a level change mid conversion waits; only that one suffers
  wire srcHold        = (state == ST_CONVERT);
  // external clock rise drives the filter; 2560 per notch
  wire extTick        = rsSync[1] && !rsPrev;
  wire next_convClkEn = extClkSel ? extTick : convTick;

  // clock source and notch, frozen while a conversion runs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      extClkSel <= 1'h0;
      intOscEn  <= 1'h1;
      notch50   <= 1'h0;
    end else if (!srcHold) begin
      extClkSel <= extSeen;
      intOscEn  <= !extSeen;
      notch50   <= rsSync[1];
    end
  end

  // selected conversion tick, never a mix of both sources
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      convClkEn <= 1'h0;
    end else begin
      convClkEn <= next_convClkEn;
    end
  end

  // conversion handshake towards the filter
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      convStart <= 1'h0;
      convBusy  <= 1'h1;
    end else begin
      convStart <= doStart;
      convBusy  <= (next_state == ST_CONVERT);
    end
  end

  // fifo overflow: a finished word had nowhere to go
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      resultLost <= 1'h0;
    end else begin
      resultLost <= convDone && !fifoInReady;
    end
  end
endmodule : adc_result_word_serializer

// >>> logic/adcws_fifo.sv
// small synchronous fifo for finished conversion words
`timescale 1ns/1ps
module adcws_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // storage
  logic [AW-1:0]    wrPtr;         // write index
  logic [AW-1:0]    rdPtr;         // read index
  logic [AW:0]      count;         // words held
  wire              doWrite = inValid && inReady;
  wire              doRead  = outValid && outReady;

  // full and empty from the count; a pointer-wide compare would wrap to 0
  assign inReady  = (count < (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];

  // storage write
  always_ff @(posedge mclk) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  // pointers and count
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end
endmodule : adcws_fifo

// >>> logic/adcws_pkg.sv
// shared constants and carriers for the result word serializer
package adcws_pkg;
  localparam int WORD_BITS    = 24;  // serial word length
  localparam int RESULT_BITS  = 20;  // result field width
  localparam int EXTRA_BITS   = 8;   // trailing always-high bits
  localparam int BUSY_POS     = 23;  // conversion-busy flag position
  localparam int CHAN_POS     = 22;  // channel flag position
  localparam int SIGN_POS     = 21;  // sign flag position
  localparam int RANGE_POS    = 20;  // range-exceeded flag position
  localparam int FIFO_WIDTH   = 24;  // fifo word width
  localparam int FIFO_DEPTH   = 8;   // fifo depth
  // clock-source detection: window timed in mclk cycles
  localparam int MCLK_HZ      = 25000000;
  localparam int MIN_EXT_HZ   = 2560;  // least detectable external clock
  localparam int NOTCH_DIV    = 2560;  // external clock per notch period
  // window long enough to see two edges of the slowest clock
  localparam int DET_WINDOW   = (MCLK_HZ + MIN_EXT_HZ - 1) / MIN_EXT_HZ;
  localparam int DET_EDGES    = 2;
  // saturation limits of the result field (one-eighth beyond the span)
  localparam logic [19:0] SAT_HIGH  = 20'h1FFFF;
  localparam logic [19:0] SAT_LOW   = 20'hE0000;
  localparam logic [23:0] WORD_RST  = 24'hFFFFFF;

  // one finished conversion as handed to the serializer
  typedef struct packed {
    logic        chan;   // 0 first_input, 1 second_input
    logic        sign;   // sign_flag
    logic        range;  // range_exceeded_flag
    logic [19:0] value;  // result field
  } adcws_result_type;

  typedef enum logic [1:0] {
    ST_CONVERT,
    ST_SLEEP,
    ST_OUTPUT
  } adcws_state_type;
endpackage : adcws_pkg

// >>> verif/adcws_chk.sv
// concurrent checks on the serializer ports
`timescale 1ns/1ps
module adcws_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic csN,
  input wire logic rejection_select_pin,
  input wire logic sdoOut,
  input wire logic sdoOe,
  input wire logic convStart,
  input wire logic convDone,
  input wire logic convBusy,
  input wire logic notch50,
  input wire logic extClkSel,
  input wire logic intOscEn
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // four samples cover the two-flop sync plus the output register
  sdo_off_a: assert property (csN [*4] |-> !sdoOe)
    else $error("data out driven with select high");
  sdo_on_a: assert property (!csN [*4] |-> sdoOe)
    else $error("data out released with select low");
  busy_fall_a: assert property (convDone |-> ##[1:5] !convBusy)
    else $error("busy did not fall after completion");
  busy_sdo_a: assert property (
    sdoOe && convBusy && $past(convBusy) |-> sdoOut)
    else $error("busy flag not shown on data out");
  start_busy_a: assert property (convStart |-> ##[0:1] convBusy)
    else $error("start pulse without conversion");
  start_pulse_a: assert property (convStart |=> !convStart)
    else $error("start pulse longer than one cycle");
  // only judged once the pin level has settled past the synchronizer
  notch_sel_a: assert property (
    (!convBusy && !extClkSel && $stable(rejection_select_pin)) [*6]
    |-> notch50 == rejection_select_pin)
    else $error("notch select does not follow pin level");
  osc_excl_a: assert property (
    extClkSel && $past(extClkSel) |-> !intOscEn)
    else $error("internal oscillator on with external clock");
  sleep_hold_a: assert property (
    (csN && !convBusy) [*8] |=> !convBusy)
    else $error("sleep left with select high");
endmodule : adcws_chk

bind adc_result_word_serializer adcws_chk u_chk (
  .mclk(mclk), .rst_n(rst_n), .csN(csN),
  .rejection_select_pin(rejection_select_pin),
  .sdoOut(sdoOut), .sdoOe(sdoOe), .convStart(convStart),
  .convDone(convDone), .convBusy(convBusy), .notch50(notch50),
  .extClkSel(extClkSel), .intOscEn(intOscEn)
);

// >>> verif/adcws_host.sv
// host model: serial port master reading result words
`timescale 1ns/1ps
module adcws_host (
  input  wire logic mclk,
  input  wire logic sdoOut,
  input  wire logic sdoOe,
  output logic      csN,
  output logic      sck
);
  logic lastSdo = 1'h0;  // last level really driven
  logic sdoLine;  // level the host sees
  // released line drifts from its last value so stale data never passes
  assign sdoLine = sdoOe ? sdoOut : ~lastSdo;
  always @(posedge mclk) begin
    if (sdoOe) begin
      lastSdo <= sdoOut;
    end
  end
  initial begin
    csN = 1'h1;
    sck = 1'h0;
  end
  // select level change, clock held low around it
  task automatic select(input logic lvl);
    @(negedge mclk);
    csN = lvl;
    repeat (6) @(negedge mclk);
  endtask : select
  // n pulses of twelve cycles, capture on rising edge, msb first
  task automatic read_bits(input int n, output logic [31:0] w);
    w = '0;
    for (int i = 0; i < n; i++) begin
      repeat (6) @(negedge mclk);
      sck = 1'h1;
      w = {w[30:0], sdoLine};
      repeat (6) @(negedge mclk);
      sck = 1'h0;
    end
  endtask : read_bits
endmodule : adcws_host

// >>> verif/test_adc_result_word_serializer.sv
// self-checking bench for the result word serializer
`timescale 1ns/1ps
module test_adc_result_word_serializer
  import adcws_pkg::*;
;
  localparam int LIMIT = 20000;  // cycle ceiling for the run
  logic             mclk, rst_n, csN, sck, rejection_select_pin;
  logic             sdoOut, sdoOe, convStart, convDone, convChan;
  logic             convTick, convBusy, notch50, extClkSel, intOscEn;
  logic             convClkEn, resultLost, extRun, pinLevel;
  adcws_result_type convResult;
  int               nErrors, checked, nTicks;
  int               cycles = 0;  // clock count for ticks and ceiling
  int               starts = 0;  // start pulses seen
  logic [31:0]      w;
  // {chan, sign, range, value} in, word with busy low out
  logic [23:0] vecIn [8] = '{24'h300000, 24'h31FFFF, 24'h1FFFFF,
    24'h1E0000, 24'h6FFFFF, 24'h600000, 24'h33FFFF, 24'h180000};
  logic [23:0] vecExp [8] = '{24'h300000, 24'h31FFFF, 24'h1FFFFF,
    24'h1E0000, 24'h6FFFFF, 24'h600000, 24'h31FFFF, 24'h1E0000};

  adc_result_word_serializer #(.DET_CYCLES(64)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .csN(csN), .sck(sck),
    .rejection_select_pin(rejection_select_pin), .sdoOut(sdoOut),
    .sdoOe(sdoOe), .convStart(convStart), .convDone(convDone),
    .convResult(convResult), .convChan(convChan), .convTick(convTick),
    .convBusy(convBusy), .notch50(notch50), .extClkSel(extClkSel),
    .intOscEn(intOscEn), .convClkEn(convClkEn), .resultLost(resultLost));
  adcws_host u_host (.mclk(mclk), .sdoOut(sdoOut), .sdoOe(sdoOe),
    .csN(csN), .sck(sck));
  ////////////////////////////////////////////////////////////////////////////
  always #20 mclk = ~mclk;
  // oscillator tick every fourth cycle, external clock of eight cycles
  always @(negedge mclk) begin
    convTick <= (cycles % 4 == 0);
    if (!extRun) begin
      rejection_select_pin <= pinLevel;
    end else if (cycles % 4 == 0) begin
      rejection_select_pin <= ~rejection_select_pin;
    end
  end
  // hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (convStart) begin
      starts <= starts + 1;
    end
    if (cycles == LIMIT) begin
      nErrors++;
      report_and_stop();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      nErrors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // finish the running conversion, busy must drop
  task automatic t_finish(input logic [23:0] r);
    int k = 0;
    @(negedge mclk);
    convResult = r[22:0];
    convChan = r[22];
    convDone = 1'h1;
    @(negedge mclk);
    convDone = 1'h0;
    while (convBusy !== 1'h0 && k < 20) begin
      @(negedge mclk);
      k++;
    end
    check("busy", convBusy, 1'h0);
  endtask : t_finish
  // every code row read back whole, trailing bits included
  task automatic t_words();
    u_host.select(1'h0);
    for (int i = 0; i < 8; i++) begin
      check("busy on sdo", sdoOut, 1'h1);
      t_finish(vecIn[i]);
      repeat (6) @(negedge mclk);
      check("busy fall", sdoOut, 1'h0);
      u_host.read_bits(32, w);
      check("word", w, {vecExp[i], 8'hFF});
      repeat (6) @(negedge mclk);
      check("restart", convBusy, 1'h1);
    end
    check("starts", starts, 32'h8);
    u_host.select(1'h1);
  endtask : t_words
  // selected conversion ticks over 80 cycles
  task automatic count_ticks(output int n);
    n = 0;
    repeat (80) begin
      @(negedge mclk);
      n += convClkEn;
    end
  endtask : count_ticks
  // read cut short, then clocks with select high are ignored
  task automatic t_abort();
    t_finish(24'h2ABCDE);
    u_host.select(1'h0);
    u_host.read_bits(5, w);
    u_host.select(1'h1);
    check("oe off", sdoOe, 1'h0);
    check("abort conv", convBusy, 1'h1);
    u_host.select(1'h0);
    check("abort busy", sdoOut, 1'h1);
    u_host.select(1'h1);
    t_finish(24'h2ABCDE);
    u_host.read_bits(3, w);
    check("still sleep", convBusy, 1'h0);
    u_host.select(1'h0);
    u_host.read_bits(24, w);
    check("word kept", w, 32'h002ABCDE);
    u_host.select(1'h1);
  endtask : t_abort
  // level select in sleep, then an external clock comes and goes
  task automatic t_select();
    pinLevel = 1'h1;
    repeat (10) @(negedge mclk);
    check("notch held", notch50, 1'h0);
    t_finish(24'h200000);
    for (int i = 0; i < 2; i++) begin
      pinLevel = i[0];
      repeat (10) @(negedge mclk);
      check("notch", notch50, i[0]);
    end
    // let the detector forget the level steps above
    repeat (130) @(negedge mclk);
    count_ticks(nTicks);
    check("int ticks", nTicks, 32'h14);
    extRun = 1'h1;
    repeat (200) @(negedge mclk);
    check("ext sel", extClkSel, 1'h1);
    check("osc off", intOscEn, 1'h0);
    count_ticks(nTicks);
    check("ext ticks", nTicks, 32'h0A);
    extRun = 1'h0;
    repeat (200) @(negedge mclk);
    check("ext gone", extClkSel, 1'h0);
    check("osc on", intOscEn, 1'h1);
  endtask : t_select
  // words finished in sleep queue up; the ninth has no room
  task automatic t_lost();
    for (int i = 0; i < 9; i++) begin
      @(negedge mclk);
      convDone = 1'h1;
      @(negedge mclk);
      convDone = 1'h0;
      check("lost", resultLost, (i == 8));
    end
  endtask : t_lost
  task automatic report_and_stop();
    if (nErrors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  initial begin
    mclk = 1'h0;
    rst_n = 1'h0;
    convDone = 1'h0;
    convResult = '0;
    convChan = 1'h0;
    pinLevel = 1'h0;
    extRun = 1'h0;
    repeat (2) @(negedge mclk);
    check("oe rst", sdoOe, 1'h0);
    check("busy rst", convBusy, 1'h1);
    rst_n = 1'h1;
    t_words();
    t_abort();
    t_select();
    t_lost();
    report_and_stop();
  end
endmodule : test_adc_result_word_serializer
